/* File: verilog/wois_slave.sv */
// Purpose: write-only two-wire slave, passes received bytes through a fifo
// Assumes: bus lines sampled by clk through two flip-flops
// Notes:   never drives the clock line and never drives data high
//
// Contract
// RULE1: master starts every transaction, never the slave
// RULE2: only write direction; no read path
// RULE3: master sends direction bit as zero
// RULE4: lines open drain; pull low or release
// RULE5: only master makes start and stop
// RULE6: bus idle high before a start
// RULE7: start is data falling while clock high
// RULE8: stop is data rising while clock high
// RULE9: master ends transfer releasing both lines
// RULE10: bytes are eight bits, msb first
// RULE11: respond only to first byte 0x98
// RULE12: slave pulls data low in ninth clock; code withholds it for a data byte while the fifo is full
// RULE13: register byte then data follow address
// RULE14: no ack on mismatch; wait next start
`default_nettype none
module wois_slave (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   wois_if.slave            bus,
   output logic [7:0]       rx_data,
   output logic             rx_first,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic             overrun_ff
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ADDR = 4'b0010,
      S_DATA = 4'b0100,
      S_IGN  = 4'b1000
   } wois_st_t;
   wois_st_t    st_ff;
   wois_st_t    nxt_st;
   logic [1:0]  scl_sy_ff;
   logic [1:0]  sda_sy_ff;
   logic        scl_d_ff;
   logic        sda_d_ff;
   logic [7:0]  sh_ff;
   logic [3:0]  cnt_ff;
   logic        ack_ff;
   logic        first_ff;
   logic        fifo_ready;
   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   // two flops per line; edges seen only after the second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sy_ff <= 2'h3;
         sda_sy_ff <= 2'h3;
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
      end else begin
         scl_sy_ff <= {scl_sy_ff[0], bus.scl};
         sda_sy_ff <= {sda_sy_ff[0], bus.sda};
         scl_d_ff  <= scl_sy_ff[1];
         sda_d_ff  <= sda_sy_ff[1];
      end
   end
   wire scl_s   = scl_sy_ff[1];
   wire sda_s   = sda_sy_ff[1];
   wire scl_ris = scl_s & ~scl_d_ff;
   wire scl_fal = ~scl_s & scl_d_ff;
   wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s; // RULE7
   wire stop_c  = scl_s & scl_d_ff & ~sda_d_ff & sda_s; // RULE8
   // count runs on to nine so the ack clock is told apart from the eighth
   wire eight   = (cnt_ff == 4'(wois_pkg::BYTE_BITS));
   wire nine    = (cnt_ff == 4'(wois_pkg::BYTE_BITS + 1));
   wire byte_in = scl_fal & eight;
   wire addr_ok = (sh_ff[7:1] == wois_pkg::DEV_ADDR_WR[7:1]) & (sh_ff[wois_pkg::DIR_BIT_POS] == 1'b0); // RULE11 RULE3
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (start_c) begin
         nxt_st = S_ADDR; // RULE7
      end else if (stop_c) begin
         nxt_st = S_IDLE; // RULE8
      end else begin
         unique case (st_ff)
            S_IDLE: nxt_st = S_IDLE;
            S_ADDR: if (scl_fal && nine) nxt_st = ack_ff ? S_DATA : S_IGN; // RULE14
            S_DATA: nxt_st = S_DATA;
            S_IGN:  nxt_st = S_IGN;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // bit shifter and acknowledge
   // ----------------------------------------------------------------
   // ack a data byte only when it can be stored; a full fifo withholds it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff      <= S_IDLE;
         sh_ff      <= 8'h00;
         cnt_ff     <= 4'h0;
         ack_ff     <= 1'b0;
         first_ff   <= 1'b0;
         overrun_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         if (start_c) begin
            cnt_ff   <= 4'h0;
            ack_ff   <= 1'b0;
            first_ff <= 1'b1;
         end else if (stop_c) begin
            ack_ff <= 1'b0; // RULE9
         end else if (st_ff == S_ADDR || st_ff == S_DATA) begin
            if (scl_ris && cnt_ff < 4'(wois_pkg::BYTE_BITS)) begin
               sh_ff  <= {sh_ff[6:0], sda_s}; // RULE10
            end
            if (scl_ris && !nine) begin
               cnt_ff <= cnt_ff + 4'h1;
            end
            if (byte_in) begin
               if (st_ff == S_ADDR) ack_ff <= addr_ok; // RULE11 RULE3
               else ack_ff <= fifo_ready; // RULE12
               overrun_ff <= overrun_ff | (st_ff == S_DATA & ~fifo_ready);
            end else if (scl_fal && nine) begin
               ack_ff <= 1'b0;
               cnt_ff <= 4'h0;
               if (st_ff == S_DATA) first_ff <= 1'b0;
            end
         end
      end
   end
   // data line only ever pulled low, clock never touched
   assign bus.sda_o_s = 1'b0;   // RULE4 RULE2
   assign bus.sda_oe_s = ack_ff; // RULE12 RULE5
   wois_fifo #(.W(wois_pkg::FIFO_WIDTH), .D(wois_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_data   ({first_ff, sh_ff}),
      .in_valid  (byte_in & (st_ff == S_DATA)),
      .in_ready  (fifo_ready),
      .out_data  ({rx_first, rx_data}),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
endmodule
`default_nettype wire

/* File: include/wois_pkg.sv */
// Purpose: shared constants for the write-only two-wire slave and its master
// Assumes: 20 MHz system clock, bus clock made by the master's divider
// Notes:   all timing counts derive from printed times and the clock rate
`default_nettype none
package wois_pkg;
   // ----------------------------------------------------------------
   // bus framing
   // ----------------------------------------------------------------
   localparam int            BYTE_BITS    = 8;
   localparam logic [7:0]    DEV_ADDR_WR  = 8'h98;
   localparam int            DIR_BIT_POS  = 0;
   localparam int            FIFO_DEPTH   = 16;
   localparam int            FIFO_WIDTH   = 9;   // byte plus first-after-start flag
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int            CLK_PERIOD_NS  = 50;
   localparam int            SCL_PERIOD_NS  = 400;
   localparam int            QTR_CYCLES     = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]    QTR_MAX        = 4'(QTR_CYCLES - 1);
endpackage
`default_nettype wire

/* File: include/wois_if.sv */
// Purpose: open-drain two-wire link between master and slave ends
// Assumes: external pull-ups modelled by wired-and of the inverted enables
// Notes:   enable high means the party pulls the line low
`default_nettype none
interface wois_if;
   logic scl_oe_m;
   logic sda_oe_m;
   logic sda_oe_s;
   logic scl_o_m;
   logic sda_o_m;
   logic sda_o_s;
   wire  scl = ~scl_oe_m;
   wire  sda = ~(sda_oe_m | sda_oe_s);
   modport master (output scl_oe_m, output sda_oe_m, output scl_o_m, output sda_o_m, input scl, input sda);
   modport slave  (output sda_oe_s, output sda_o_s, input scl, input sda);
endinterface
`default_nettype wire

/* File: verilog/wois_fifo.sv */
// Purpose: parameterised valid/ready fifo for received bytes
// Assumes: single clock, power-of-two depth
// Notes:   full and empty from a one-bit-wider pointer pair
`default_nettype none
module wois_fifo #(
   parameter int W = 9,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW:0]   wr_ff;
   logic [AW:0]   rd_ff;
   wire           full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   wire           empty = (wr_ff == rd_ff);
   wire           push  = in_valid & ~full;
   wire           pop   = out_ready & ~empty;
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rd_ff[AW-1:0]];
   // storage has no reset; only pointers need a defined state
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
   // pointers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop)  rd_ff <= rd_ff + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/wois_master.sv */
// Purpose: two-wire master end: address, register, data writes
// Assumes: user holds cmd fields stable while cmd_valid is high
// Notes:   bus clock from a quarter-period enable divider
`default_nettype none
module wois_master (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   wois_if.master           bus,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [7:0]  cmd_byte,
   input  wire logic        cmd_last,
   output logic             nack_ff
);
   typedef enum logic [5:0] {
      M_IDLE = 6'b000001,
      M_STA  = 6'b000010,
      M_BIT  = 6'b000100,
      M_ACK  = 6'b001000,
      M_STO  = 6'b010000,
      M_LOAD = 6'b100000
   } wois_mst_t;
   wois_mst_t   st_ff;
   logic [3:0]  div_ff;
   logic [1:0]  ph_ff;
   logic [7:0]  sh_ff;
   logic [2:0]  bit_ff;
   logic        last_ff;
   logic        scl_pull_ff;
   logic        sda_pull_ff;
   logic [1:0]  sda_sy_ff;
   // ----------------------------------------------------------------
   // divider: one tick each quarter of the bus clock
   // ----------------------------------------------------------------
   wire tick = (div_ff == wois_pkg::QTR_MAX);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) div_ff <= 4'h0;
      else div_ff <= tick ? 4'h0 : div_ff + 4'h1;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) sda_sy_ff <= 2'h3;
      else sda_sy_ff <= {sda_sy_ff[0], bus.sda};
   end
   assign cmd_ready = (st_ff == M_LOAD) & tick;
   // ----------------------------------------------------------------
   // sequencer: phase 0 scl low set data, 1-2 scl high, 3 scl low
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff       <= M_IDLE;
         ph_ff       <= 2'h0;
         sh_ff       <= 8'h00;
         bit_ff      <= 3'h0;
         last_ff     <= 1'b0;
         scl_pull_ff <= 1'b0;
         sda_pull_ff <= 1'b0;
         nack_ff     <= 1'b0;
      end else if (tick) begin
         ph_ff <= ph_ff + 2'h1;
         unique case (st_ff)
            M_IDLE: begin
               ph_ff <= 2'h0;
               if (cmd_valid) st_ff <= M_STA; // RULE1 RULE6
            end
            M_STA: begin
               if (ph_ff == 2'h1) sda_pull_ff <= 1'b1; // RULE7
               if (ph_ff == 2'h3) begin
                  scl_pull_ff <= 1'b1;
                  sh_ff       <= wois_pkg::DEV_ADDR_WR; // RULE3 RULE11
                  bit_ff      <= 3'h7;
                  last_ff     <= 1'b0;
                  st_ff       <= M_BIT;
               end
            end
            M_BIT: begin
               if (ph_ff == 2'h0) sda_pull_ff <= ~sh_ff[7]; // RULE10 RULE4
               if (ph_ff == 2'h1) scl_pull_ff <= 1'b0;
               if (ph_ff == 2'h3) begin
                  scl_pull_ff <= 1'b1;
                  sh_ff       <= {sh_ff[6:0], 1'b0};
                  bit_ff      <= bit_ff - 3'h1;
                  if (bit_ff == 3'h0) st_ff <= M_ACK;
               end
            end
            M_ACK: begin
               if (ph_ff == 2'h0) sda_pull_ff <= 1'b0; // RULE12
               if (ph_ff == 2'h1) scl_pull_ff <= 1'b0;
               if (ph_ff == 2'h2) nack_ff <= sda_sy_ff[1];
               if (ph_ff == 2'h3) begin
                  scl_pull_ff <= 1'b1;
                  st_ff <= (last_ff | nack_ff) ? M_STO : M_LOAD; // RULE13
               end
            end
            M_LOAD: begin
               ph_ff <= 2'h0;
               if (cmd_valid) begin
                  sh_ff   <= cmd_byte;
                  last_ff <= cmd_last;
                  bit_ff  <= 3'h7;
                  st_ff   <= M_BIT;
               end
            end
            M_STO: begin
               if (ph_ff == 2'h0) sda_pull_ff <= 1'b1;
               if (ph_ff == 2'h1) scl_pull_ff <= 1'b0; // RULE8
               if (ph_ff == 2'h2) sda_pull_ff <= 1'b0; // RULE9 RULE5
               if (ph_ff == 2'h3) st_ff <= M_IDLE;
            end
         endcase
      end
   end
   assign bus.scl_o_m  = 1'b0;
   assign bus.sda_o_m  = 1'b0;
   assign bus.scl_oe_m = scl_pull_ff;
   assign bus.sda_oe_m = sda_pull_ff;
endmodule
`default_nettype wire

/* File: verification/wois_props.sv */
// Purpose: wire-level checks on the master-slave link
// Assumes: one clock domain, async high reset
// Notes:   sees interface signals only
`default_nettype none
module wois_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_oe_s,
   input wire logic scl_oe_m,
   input wire logic sda_oe_m
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // frame tracking
   // ----------------------------------------
   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence
   logic [7:0] pulses_ff;
   // clock pulses since the last start; a byte is nine of them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulses_ff <= 8'h00;
      end else if (scl && $past(scl) && $fell(sda)) begin
         pulses_ff <= 8'h00;
      end else if ($rose(scl)) begin
         pulses_ff <= pulses_ff + 8'h01;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_start_then_low: assert property (start_s |-> ##[1:8] !scl)
      else $error("clock not pulled low after start");
   a_stop_goes_idle: assert property (stop_s |=> sda && scl)
      else $error("bus not idle after stop");
   a_start_from_idle: assert property (start_s |-> $past(sda, 2) && $past(scl, 2))
      else $error("start from a busy bus");
   a_byte_framing: assert property (stop_s |-> (pulses_ff % 8'h09) == 8'h01)
      else $error("stop not on a byte boundary");
   a_ack_ninth: assert property ($rose(sda_oe_s) |-> (pulses_ff % 8'h09) == 8'h08)
      else $error("acknowledge outside the ninth clock");
   a_slave_no_cond: assert property ($rose(sda_oe_s) |-> !scl)
      else $error("slave pulled data while clock high");
   a_ack_release: assert property ($fell(sda_oe_s) |-> !scl)
      else $error("slave released data while clock high");
   a_ack_bounded: assert property ($rose(sda_oe_s) |-> sda_oe_s[*4] ##[1:16] !sda_oe_s)
      else $error("acknowledge too short or stuck");
   a_reset_idle: assert property ($fell(sys_rst) |-> scl && sda)
      else $error("line pulled at reset release");
endmodule
`default_nettype wire

/* File: verification/write_only_i2c_slave_tb.sv */
// Purpose: bench for the two-wire master and write-only slave
// Assumes: 20 MHz clk, fifo of 16 entries
// Notes:   a second link is bit-banged to offer refused addresses
`default_nettype none
module write_only_i2c_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       cmd_valid = 1'b0;
   logic       cmd_ready;
   logic [7:0] cmd_byte = 8'h00;
   logic       cmd_last = 1'b0;
   logic       nack_ff;
   logic [7:0] rx_data;
   logic       rx_first;
   logic       rx_valid;
   logic       rx_ready = 1'b0;
   logic       overrun_ff;
   logic       hold = 1'b1;
   logic       b_scl_oe = 1'b0;
   logic       b_sda_oe = 1'b0;
   int         fails = 0;
   int         n_tests = 0;
   int         cyc = 0;
   logic [8:0] expq[$];
   wois_if lnk();
   wois_if bif();
   assign bif.scl_oe_m = b_scl_oe;
   assign bif.sda_oe_m = b_sda_oe;
   wois_master u_wois_master (.clk(clk), .sys_rst(sys_rst), .bus(lnk.master), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .cmd_last(cmd_last), .nack_ff(nack_ff));
   wois_slave u_wois_slave (.clk(clk), .sys_rst(sys_rst), .bus(lnk.slave), .rx_data(rx_data),
      .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .overrun_ff(overrun_ff));
   wois_slave u_wois_slave_b (.clk(clk), .sys_rst(sys_rst), .bus(bif.slave), .rx_data(),
      .rx_first(), .rx_valid(), .rx_ready(1'b1), .overrun_ff());
   wois_props u_wois_props (.clk(clk), .sys_rst(sys_rst), .scl(lnk.scl), .sda(lnk.sda),
      .sda_oe_s(lnk.sda_oe_s), .scl_oe_m(lnk.scl_oe_m), .sda_oe_m(lnk.sda_oe_m));
   // ----------------------------------------
   // clock, timeout, receive monitor
   // ----------------------------------------
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rx_ready <= hold ? 1'b0 : 1'($urandom % 2);
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         chk_rx((expq.size() > 0) ? expq.pop_front() : 9'h1FF, {rx_first, rx_data});
      end
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   task automatic chk_rx(input logic [8:0] e, input logic [8:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value rx byte exp %h got %h", e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // master side driver
   // ----------------------------------------
   // valid stays up between bytes so no edge sees it assigned twice
   task automatic send(input logic [7:0] b, input logic last, input logic first, input logic keep);
      int n;
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      cmd_last <= last;
      n = 0;
      @(posedge clk);
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) fails++;
      if (keep) expq.push_back({first, b});
      if (last) cmd_valid <= 1'b0;
   endtask
   task automatic settle();
      int k;
      k = 0;
      for (int n = 0; n < 3000 && k < 20; n++) begin
         @(posedge clk);
         k = (lnk.sda === 1'b1 && lnk.scl === 1'b1) ? k + 1 : 0;
      end
   endtask
   // register byte then n data bytes; only the first keep_n reach the fifo
   task automatic txn(input int n, input int keep_n);
      send(8'($urandom), n == 0, 1'b1, 1'b1);
      for (int i = 1; i <= n; i++) send(8'($urandom), i == n, 1'b0, i < keep_n);
      settle();
   endtask
   task automatic drain();
      hold <= 1'b0;
      for (int n = 0; n < 3000 && expq.size() > 0; n++) @(posedge clk);
      chk_bit("queue empty", 1'b1, expq.size() == 0);
   endtask
   // ----------------------------------------
   // bit-banged second link
   // ----------------------------------------
   task automatic tick();
      repeat (2) @(posedge clk);
   endtask
   task automatic bb_start();
      b_sda_oe <= 1'b1;
      tick();
      b_scl_oe <= 1'b1;
      tick();
   endtask
   task automatic bb_byte(input logic [7:0] b, input logic exp);
      for (int i = 8; i >= 0; i--) begin
         b_sda_oe <= (i > 0) ? ~b[i-1] : 1'b0;
         tick();
         b_scl_oe <= 1'b0;
         tick();
         if (i == 0) chk_bit("ack", exp, ~bif.sda);
         tick();
         b_scl_oe <= 1'b1;
         tick();
      end
   endtask
   task automatic bb_stop();
      b_sda_oe <= 1'b1;
      tick();
      b_scl_oe <= 1'b0;
      tick();
      b_sda_oe <= 1'b0;
      repeat (4) tick();
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(65));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      hold <= 1'b0;
      txn(3, 4);
      drain();
      chk_bit("nack", 1'b0, nack_ff);
      hold <= 1'b1;
      txn(16, 16);
      chk_bit("overrun", 1'b1, overrun_ff);
      chk_bit("nack", 1'b1, nack_ff);
      drain();
      txn(0, 1);
      drain();
      bb_start();
      bb_byte(8'h99, 1'b0);
      bb_stop();
      bb_start();
      bb_byte(8'h9A, 1'b0);
      bb_byte(8'h98, 1'b0);
      bb_stop();
      bb_start();
      bb_byte(8'h98, 1'b1);
      bb_byte(8'h01, 1'b1);
      bb_stop();
      conclude();
   end
endmodule
`default_nettype wire
